// File: common/mpks_params.svh
// Purpose: timing constants and codes for the module power key sequencer
// Assumes: 100 MHz clock
// Notes: long counts are top parameters; these are their defaults
`ifndef MPKS_PARAMS_SVH
`define MPKS_PARAMS_SVH
`define MPKS_CLK_HZ 100000000
`define MPKS_ON_PRESS_MS 1000
`define MPKS_OFF_PRESS_MS 2500
`define MPKS_BOOT_MS 20000
`define MPKS_EOFF_MS 200
`define MPKS_PAD_CFG_MS 10000
`define MPKS_FINAL_MS 10000
`define MPKS_MS_CYC (`MPKS_CLK_HZ / 1000)
`define MPKS_CNT_W 32
`define MPKS_TRUE 1'b1
`define MPKS_FALSE 1'b0
`endif

// File: common/mpks_pkg.sv
// Purpose: types for the module power key sequencer
// Assumes: nothing
// Notes: power states of the device
package mpks_pkg;
  typedef enum logic [2:0] {
    MPKS_OFF,
    MPKS_INIT,
    MPKS_ACTIVE,
    MPKS_DETACH,
    MPKS_FINAL
  } mpks_state_t;
endpackage

// File: rtl/mpks_device.sv
// Purpose: device-side power sequencing of a cellular module
// Assumes: pins synchronous to clk; battery_supply high means supply present
// Notes: boot, pad config and finalization are modelled by timers
// Behaviour
// - the module becomes operational no sooner than twenty seconds after key assertion, nineteen after supply if the key is tied low.
// - commands are refused while initializing and accepted only when active.
// - software_ready goes high once power-up is complete and commands are accepted.
// - software_ready is presented on general pin 8 unless that pin is reconfigured.
// - power_monitor goes high once all pads are configured during initialization.
// - power_monitor goes low when the module has powered off.
// - shutdown by command, by a long power key press, or by the emergency pin.
// - command and key shutdowns send a network detach first; the emergency path does not.
// - a key tied low starts power-on as soon as battery supply appears.
`timescale 1ns/1ps
`default_nettype none
`include "mpks_params.svh"
module mpks_device #(
  parameter int unsigned ON_PRESS_CYC = `MPKS_ON_PRESS_MS * `MPKS_MS_CYC,
  parameter int unsigned OFF_PRESS_CYC = `MPKS_OFF_PRESS_MS * `MPKS_MS_CYC,
  parameter int unsigned BOOT_CYC = `MPKS_BOOT_MS * `MPKS_MS_CYC,
  parameter int unsigned EOFF_CYC = `MPKS_EOFF_MS * `MPKS_MS_CYC,
  parameter int unsigned PAD_CFG_CYC = `MPKS_PAD_CFG_MS * `MPKS_MS_CYC,
  parameter int unsigned FINAL_CYC = `MPKS_FINAL_MS * `MPKS_MS_CYC
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic battery_supply,
  input wire logic power_key_n,
  input wire logic emergency_off_n,
  input wire logic shutdown_command,
  input wire logic gpio8_alt_sel,
  input wire logic gpio8_alt_out,
  input wire logic cmd_valid,
  output logic cmd_accept,
  output logic cmd_refused,
  output logic software_ready,
  output logic gpio8_out,
  output logic power_monitor,
  output logic detach_request,
  output logic powered_on
);
  mpks_pkg::mpks_state_t state_r;
  mpks_pkg::mpks_state_t state_nxt;
  logic [`MPKS_CNT_W-1:0] key_cnt_r;
  logic [`MPKS_CNT_W-1:0] eoff_cnt_r;
  logic [`MPKS_CNT_W-1:0] boot_cnt_r;
  logic key_release_on;
  logic key_release_off;
  logic eoff_fire;
  logic eoff_armed_r;
  logic key_low_r;
  logic supply_r;
  logic final_load;
  logic final_done;
  logic booted;
  logic pads_done;

  // key level one cycle back, for release detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_low_r <= `MPKS_FALSE;
    end else begin
      key_low_r <= !power_key_n;
    end
  end

  // supply level one cycle back; leaving reset reads as supply just applied
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      supply_r <= `MPKS_FALSE;
    end else begin
      supply_r <= battery_supply;
    end
  end

  // press length measured while key low; judged on release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_cnt_r <= '0;
    end else if (!power_key_n && battery_supply) begin
      if (key_cnt_r != '1)
        key_cnt_r <= key_cnt_r + 1'b1;
    end else if (power_key_n) begin
      key_cnt_r <= '0;
    end
  end

  // start needs a held press, or a key already low when supply arrives;
  // a plain low level would let any short press start the module
  assign key_release_on = (key_low_r && power_key_n && key_cnt_r >= ON_PRESS_CYC) ||
                          (!power_key_n && battery_supply && !supply_r);
  assign key_release_off = key_low_r && power_key_n &&
                           key_cnt_r >= OFF_PRESS_CYC;

  // emergency pin: held low long enough, acted on at release
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      eoff_cnt_r <= '0;
      eoff_armed_r <= `MPKS_FALSE;
    end else if (!emergency_off_n) begin
      if (eoff_cnt_r != '1)
        eoff_cnt_r <= eoff_cnt_r + 1'b1;
      eoff_armed_r <= (eoff_cnt_r + 1'b1 >= EOFF_CYC);
    end else begin
      eoff_cnt_r <= '0;
      eoff_armed_r <= `MPKS_FALSE;
    end
  end
  assign eoff_fire = eoff_armed_r && emergency_off_n;

  // boot time counted from power-on entry
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      boot_cnt_r <= '0;
    end else if (state_r != mpks_pkg::MPKS_INIT) begin
      boot_cnt_r <= '0;
    end else if (boot_cnt_r != '1) begin
      boot_cnt_r <= boot_cnt_r + 1'b1;
    end
  end
  assign pads_done = boot_cnt_r + 1'b1 >= PAD_CFG_CYC;
  // key press time counts toward the twenty second minimum
  assign booted = boot_cnt_r + ON_PRESS_CYC + 1'b1 >= BOOT_CYC;

  // finalization duration timer
  assign final_load = (state_r == mpks_pkg::MPKS_DETACH);
  mpks_timer u_final (
    .clk(clk),
    .arst_n(arst_n),
    .load(final_load),
    .value(`MPKS_CNT_W'(FINAL_CYC)),
    .run(state_r == mpks_pkg::MPKS_FINAL),
    .done(final_done)
  );

  // power state sequencing
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      mpks_pkg::MPKS_OFF:
        if (battery_supply && emergency_off_n && key_release_on)
          state_nxt = mpks_pkg::MPKS_INIT;
      mpks_pkg::MPKS_INIT:
        if (booted)
          state_nxt = mpks_pkg::MPKS_ACTIVE;
      mpks_pkg::MPKS_ACTIVE:
        if (shutdown_command || key_release_off)
          state_nxt = mpks_pkg::MPKS_DETACH;
      mpks_pkg::MPKS_DETACH:
        state_nxt = mpks_pkg::MPKS_FINAL;
      mpks_pkg::MPKS_FINAL:
        if (final_done)
          state_nxt = mpks_pkg::MPKS_OFF;
    endcase
    // supply loss or emergency release overrides every state, no detach
    if (eoff_fire || !battery_supply)
      state_nxt = mpks_pkg::MPKS_OFF;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n)
      state_r <= mpks_pkg::MPKS_OFF;
    else
      state_r <= state_nxt;
  end

  // ready line and its default pin, registered from next state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      software_ready <= `MPKS_FALSE;
      gpio8_out <= `MPKS_FALSE;
    end else begin
      software_ready <= (state_nxt == mpks_pkg::MPKS_ACTIVE);
      gpio8_out <= gpio8_alt_sel ? gpio8_alt_out :
                   (state_nxt == mpks_pkg::MPKS_ACTIVE);
    end
  end

  // monitor high from pad setup through finalization, low when off and during init until pads are done
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      power_monitor <= `MPKS_FALSE;
    end else begin
      power_monitor <= (state_nxt == mpks_pkg::MPKS_ACTIVE) ||
                       (state_nxt == mpks_pkg::MPKS_DETACH) ||
                       (state_nxt == mpks_pkg::MPKS_FINAL) ||
                       (state_nxt == mpks_pkg::MPKS_INIT && pads_done);
    end
  end

  // one-cycle detach strobe; the emergency path never passes here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      detach_request <= `MPKS_FALSE;
    end else begin
      detach_request <= (state_nxt == mpks_pkg::MPKS_DETACH);
    end
  end

  // command gate judged on the current state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_accept <= `MPKS_FALSE;
      cmd_refused <= `MPKS_FALSE;
    end else begin
      cmd_accept <= cmd_valid && state_r == mpks_pkg::MPKS_ACTIVE;
      cmd_refused <= cmd_valid && state_r != mpks_pkg::MPKS_ACTIVE;
    end
  end

  // powered indication, high in every state but off
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      powered_on <= `MPKS_FALSE;
    end else begin
      powered_on <= (state_nxt != mpks_pkg::MPKS_OFF);
    end
  end
endmodule
`default_nettype wire

// File: rtl/mpks_timer.sv
// Purpose: loadable down counter with done pulse
// Assumes: load has priority over counting
// Notes: done is a one-cycle pulse on reaching zero
`timescale 1ns/1ps
`default_nettype none
`include "mpks_params.svh"
module mpks_timer (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic load,
  input wire logic [`MPKS_CNT_W-1:0] value,
  input wire logic run,
  output logic done
);
  logic [`MPKS_CNT_W-1:0] cnt_r;
  // count down while run, pulse done when last cycle elapses
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r <= '0;
      done <= `MPKS_FALSE;
    end else if (load) begin
      cnt_r <= value;
      done <= `MPKS_FALSE;
    end else if (run && cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
      done <= (cnt_r == `MPKS_CNT_W'(1));
    end else begin
      done <= `MPKS_FALSE;
    end
  end
endmodule
`default_nettype wire

// File: testbench/mpks_device_chk.sv
// Purpose: port checks on the sequencer
// Assumes: one clock, async low reset
// Notes: bound to mpks_device
`timescale 1ns/1ps
`default_nettype none
module mpks_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic battery_supply,
  input wire logic gpio8_alt_sel,
  input wire logic gpio8_alt_out,
  input wire logic cmd_valid,
  input wire logic cmd_accept,
  input wire logic cmd_refused,
  input wire logic software_ready,
  input wire logic gpio8_out,
  input wire logic power_monitor,
  input wire logic detach_request,
  input wire logic powered_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_acc; cmd_valid && software_ready |=> cmd_accept; endproperty
  a_acc: assert property (p_acc) else $error("no accept");
  property p_rfs; cmd_valid && !software_ready |=> cmd_refused && !cmd_accept; endproperty
  a_rfs: assert property (p_rfs) else $error("no refusal");
  property p_g8; $past(!gpio8_alt_sel) && $stable(software_ready) |-> gpio8_out == software_ready;
  endproperty
  a_g8: assert property (p_g8) else $error("pin 8 not ready");
  property p_alt; $past(gpio8_alt_sel) && $stable(gpio8_alt_out) |-> gpio8_out == gpio8_alt_out;
  endproperty
  a_alt: assert property (p_alt) else $error("pin 8 alt");
  property p_pm; software_ready |-> power_monitor && powered_on; endproperty
  a_pm: assert property (p_pm) else $error("ready before pads");
  property p_off; !powered_on |-> !power_monitor && !software_ready; endproperty
  a_off: assert property (p_off) else $error("monitor high off");
  property p_det; detach_request |-> $past(software_ready) ##1 !detach_request; endproperty
  a_det: assert property (p_det) else $error("bad detach");
  property p_sup; !battery_supply |=> !powered_on; endproperty
  a_sup: assert property (p_sup) else $error("on without supply");
endmodule
bind mpks_device mpks_chk u_chk (.*);
`default_nettype wire

// File: testbench/mpks_host.sv
// Purpose: host partner driving the key pins
// Assumes: len counts clk cycles
// Notes: sel high pulses the emergency pin
`timescale 1ns/1ps
`default_nettype none
module mpks_host (
  input wire logic clk,
  input wire logic go,
  input wire logic sel,
  input wire logic [7:0] len,
  output logic key_n,
  output logic eoff_n,
  output logic busy
);
  logic [7:0] cnt_r = 8'h00;
  // press timed on own clock, then released
  always_ff @(posedge clk) begin
    if (go) begin
      cnt_r <= len;
    end else if (busy) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
  assign busy = cnt_r != 8'h00;
  assign key_n = !(busy && !sel);
  assign eoff_n = !(busy && sel);
endmodule
`default_nettype wire

// File: testbench/tb_module_power_key_sequencer.sv
// Purpose: self-checking bench for the sequencer
// Assumes: shortened timing parameters
// Notes: expected values from the state rules
`timescale 1ns/1ps
`default_nettype none
module tb_module_power_key_sequencer;
  logic clk = 1'b0, arst_n = 1'b0, bat = 1'b1, cmd = 1'b0, vld = 1'b0;
  logic asel = 1'b0, aout = 1'b0, go = 1'b0, sel = 1'b0, tie = 1'b0;
  logic [7:0] len = 8'h00;
  logic acc, rfs, rdy, g8, pm, det, pon, hk, he, busy;
  int fails = 0, checked = 0, t = 0, ndet = 0, edet = 0, cyc = 0, t0 = 0;
  integer seed = 32'hd78c;
  // shortened timing, in clock cycles
  localparam int unsigned ON_C = 10, OFF_C = 25, BOOT_C = 200, EOFF_C = 5;
  localparam int unsigned PAD_C = 100, FIN_C = 50;
  // clock, cycle count and detach counter
  always #5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  always @(posedge clk) if (det === 1'b1) ndet++;
  mpks_host host (.clk(clk), .go(go), .sel(sel), .len(len), .key_n(hk), .eoff_n(he),
    .busy(busy));
  mpks_device #(.ON_PRESS_CYC(ON_C), .OFF_PRESS_CYC(OFF_C), .BOOT_CYC(BOOT_C),
    .EOFF_CYC(EOFF_C), .PAD_CFG_CYC(PAD_C), .FINAL_CYC(FIN_C)) dut (.clk(clk), .arst_n(arst_n),
    .battery_supply(bat),
    .power_key_n(hk & ~tie), .emergency_off_n(he), .shutdown_command(cmd), .gpio8_alt_sel(asel),
    .gpio8_alt_out(aout), .cmd_valid(vld), .cmd_accept(acc), .cmd_refused(rfs),
    .software_ready(rdy), .gpio8_out(g8), .power_monitor(pm), .detach_request(det),
    .powered_on(pon));
  task chk(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %0t mismatch", $time);
    end
  endtask
  task press(input logic s, input int n);
    @(posedge clk);
    t0 = cyc;
    sel <= s;
    len <= n[7:0];
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (n + 6) @(posedge clk);
    #1;
  endtask
  task pulse(input logic c);
    @(posedge clk);
    cmd <= c;
    vld <= !c;
    @(posedge clk);
    cmd <= 1'b0;
    vld <= 1'b0;
    #1;
  endtask
  task automatic waitfor(ref logic s, input logic v);
    t = 0;
    while (s !== v && t < 400) begin
      @(posedge clk);
      #1;
      t++;
    end
    if (s !== v) begin
      fails++;
      $display("CHECK FAILED %0t wait timed out", $time);
    end
  endtask
  task report_and_stop;
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    press(1'b0, ON_C - 1);
    chk(pon, 1'b0);
    pulse(1'b1);
    chk(pon, 1'b0);
    press(1'b0, ON_C + ($random(seed) & 7));
    chk(pon, 1'b1);
    pulse(1'b0);
    chk(rfs, 1'b1);
    waitfor(rdy, 1'b1);
    chk(t > 170 && t < 200, 1'b1);
    chk(cyc - t0 - 2 >= BOOT_C, 1'b1);
    chk(pm, 1'b1);
    chk(g8, rdy);
    pulse(1'b0);
    chk(acc, 1'b1);
    @(posedge clk);
    asel <= 1'b1;
    aout <= 1'($random(seed));
    repeat (3) @(posedge clk);
    #1;
    chk(g8, aout);
    @(posedge clk);
    asel <= 1'b0;
    $display("power on done");
    for (int k = 0; k < 3; k++) begin
      if (k > 0) begin
        press(1'b0, ON_C + 2);
        waitfor(rdy, 1'b1);
      end
      if (k == 1) begin
        press(1'b0, OFF_C - 1);
        chk(rdy, 1'b1);
      end
      if (k == 0) pulse(1'b1);
      else press(k == 2, (k == 1) ? OFF_C + 5 : EOFF_C + 1);
      edet += (k < 2);
      waitfor(pm, 1'b0);
      chk(pon, 1'b0);
      chk(ndet == edet, 1'b1);
      $display("shutdown %0d done", k);
    end
    @(posedge clk);
    bat <= 1'b0;
    tie <= 1'b1;
    repeat (3) @(posedge clk);
    bat <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(pon, 1'b1);
    $display("tied key done");
    report_and_stop();
  end
  // watchdog
  initial begin
    #50000;
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
